// file: src/hcr_map.svh
// Offsets, field positions, reset values and timing figures of the report handler.
`ifndef HCR_MAP_SVH
`define HCR_MAP_SVH
// Report codes carried in byte 0 of every control transfer.
`define HCR_CODE_VERSION 8'h46
`define HCR_CODE_LOCK 8'h47
`define HCR_CODE_XFER 8'h48
`define HCR_CODE_PINS 8'h49
// Transfer sizes in bytes, report code included.
`define HCR_LEN_VERSION 4'h7
`define HCR_LEN_LOCK 4'h3
`define HCR_LEN_XFER 4'h3
`define HCR_LEN_PINS 4'hD
`define HCR_BUF_BYTES 13
// Lock value reset image and the bits that name real fields.
`define HCR_LOCK_RESET 16'hFF8F
`define HCR_LOCK_VALID 16'hFF8F
// Transfer mode reset values.
`define HCR_TXW_RESET 1'h0
`define HCR_RXW_RESET 1'h0
`define HCR_LOWLAT_RESET 1'h1
// Pin setup reset values for divisors and mode bytes.
`define HCR_DIV_RESET 8'h00
`define HCR_MODE0_RESET 8'h01
`define HCR_MODE1_RESET 8'h00
// Mode byte field positions.
`define HCR_M1_CLK_EN 0
`define HCR_M1_TXT_EN 6
`define HCR_M1_RXT_EN 7
`define HCR_M0_MODEM_MSB 2
`define HCR_M0_RS485_MSB 6
`define HCR_M0_RS485_LSB 5
// Wishbone byte addresses.
`define HCR_REG_CTRL 7'h00
`define HCR_REG_STATUS 7'h04
`define HCR_REG_GPIO_LEVEL 7'h08
`define HCR_REG_GPIO_IN 7'h0C
`define HCR_REG_LOCK 7'h10
`define HCR_REG_BUF_BASE 7'h40
// Control register fields.
`define HCR_CTRL_GO 0
`define HCR_CTRL_GET 1
`define HCR_CTRL_LEN_LSB 8
// Clock output timing, in MHz.
`define HCR_SYS_MHZ 50
`define HCR_OUT_BASE_MHZ 24
`endif

// file: src/hcr_pkg.sv
// Types shared by the report handler modules.
`include "hcr_map.svh"
package hcr_pkg;
    // One report byte.
    typedef logic [7:0] hcr_byte_t;
    // One bit per general-purpose pin.
    typedef logic [9:0] hcr_pins_t;
    // Recognised report codes.
    typedef enum logic [7:0] {
        HCR_RPT_VERSION = `HCR_CODE_VERSION,
        HCR_RPT_LOCK = `HCR_CODE_LOCK,
        HCR_RPT_XFER = `HCR_CODE_XFER,
        HCR_RPT_PINS = `HCR_CODE_PINS
    } hcr_code_t;
endpackage : hcr_pkg

// file: src/hcr_clk_if.sv
// Divisor settings and generated clock level between handler and clock generator.
`timescale 1ns/1ps
interface hcr_clk_if;
    logic [7:0] div_hi; // High period divisor.
    logic [7:0] div_lo; // Low period divisor.
    logic enable; // Clock output function enabled.
    logic clk_level; // Generated clock level.
    modport ctrl (output div_hi, output div_lo, output enable, input clk_level);
    modport gen (input div_hi, input div_lo, input enable, output clk_level);
endinterface : hcr_clk_if

// file: src/hcr_clkgen.sv
// Divided clock output generator driven by a fractional tick enable.
`timescale 1ns/1ps
module hcr_clkgen
    import hcr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    hcr_clk_if.gen cif
);
    // Tick rate is twice the base rate so a half period of one base unit fits.
    localparam logic [6:0] TICK_STEP = 7'(2 * `HCR_OUT_BASE_MHZ);
    localparam logic [6:0] SYS_STEP = 7'(`HCR_SYS_MHZ);
    if (2 * `HCR_OUT_BASE_MHZ > `HCR_SYS_MHZ) begin : g_bad_rate
        $error("Tick rate must not exceed the system clock rate.");
    end
    logic [6:0] acc_q; // Fractional phase accumulator.
    logic [8:0] cnt_q; // Ticks spent in the current half period.
    logic phase_q; // Current clock level.
    // Accumulator sum and tick enable.
    wire [6:0] acc_sum = acc_q + TICK_STEP;
    wire tick = acc_sum >= SYS_STEP;
    // Half periods in ticks; both zero gives one tick each.
    wire both_zero = (cif.div_hi == 8'h00) && (cif.div_lo == 8'h00);
    wire [8:0] hi_len = both_zero ? 9'h001 : {cif.div_hi, 1'b0};
    wire [8:0] lo_len = both_zero ? 9'h001 : {cif.div_lo, 1'b0};
    wire [8:0] cur_len = phase_q ? hi_len : lo_len;
    wire [8:0] oth_len = phase_q ? lo_len : hi_len;
    wire half_end = (cnt_q + 9'h001) >= cur_len;
    assign cif.clk_level = phase_q;
    // Accumulator runs freely; the tick is an enable, not a clock.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_q <= 7'h00;
        end else begin
            acc_q <= tick ? 7'(acc_sum - SYS_STEP) : acc_sum;
        end
    end
    // Half period counter; a zero-length phase is skipped so the level stays put.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_q <= 9'h000;
            phase_q <= 1'b0;
        end else if (!cif.enable) begin
            cnt_q <= 9'h000; // R21
            phase_q <= 1'b0;
        end else if (tick) begin
            if (half_end) begin
                cnt_q <= 9'h000; // R20
                phase_q <= (oth_len == 9'h000) ? phase_q : ~phase_q;
            end else begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end
    // A disabled generator holds its output low from the next edge.
    a_clk_idle_low: assert property (@(posedge clk_sys) disable iff (reset)
        !cif.enable |=> !cif.clk_level) else $error("Clock ran while disabled."); // R21
endmodule : hcr_clkgen

// file: src/hcr_top.sv
// Configuration report handler with Wishbone access and pin control.
`timescale 1ns/1ps
// Contract
// R01 - Version query returns product byte and revision
// R02 - Lock report code 0x47, three bytes
// R03 - Zero bit in lock value locks field
// R04 - Locked fields never unlock or change; lock bits never return to one, but no field write checks them
// R05 - All-zero lock value locks every field
// R06 - Lock bits map thirteen fields, 6:4 reserved
// R07 - Transfer mode code 0x48, TX wide default off
// R08 - Offset 2 bit 0 enables RX wide
// R09 - Offset 2 bit 1 low latency, default on
// R10 - Pin setup code 0x49, thirteen byte layout
// R11 - Direction bit zero input, one output
// R12 - Drive bit zero open drain, one push-pull
// R13 - Pull-up bit enables weak pull-up on input
// R14 - Pull-down enabled unless pull-up also set
// R15 - Pin settings apply at once, volatile
// R16 - Special function pins ignore pin fields
// R17 - Power-up pin defaults from stored configuration
// R18 - Offsets 9 and 10 set clock divisors
// R19 - Mode bytes control half-duplex, clock, toggles
// R20 - Clock is base over divisor sum
// R21 - Clock output only when mode bit set
// R22 - Field bits map to ten pins
// R23 - Unknown code or wrong length rejected unchanged
module hcr_top
    import hcr_pkg::*;
#(
    parameter hcr_byte_t PRODUCT_ID_LOW = 8'hA5, // Arbitrary value.
    parameter hcr_byte_t REVISION = 8'h3C // Arbitrary value.
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [6:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [9:0] pin_i,
    output logic [9:0] pin_o,
    output logic [9:0] pin_oe_n,
    output logic [9:0] pin_pu_en,
    output logic [9:0] pin_pd_en,
    input wire logic [9:0] sf_level,
    input wire logic [9:0] sf_drive,
    input wire logic [15:0] stored_dir,
    input wire logic [15:0] stored_drv,
    input wire logic [15:0] stored_pu,
    input wire logic [15:0] stored_pd,
    output logic tx_wide,
    output logic rx_wide,
    output logic low_latency,
    output logic [15:0] lock_state
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Gathers the ten pin bits out of a 16-bit pin field.
    function automatic hcr_pins_t pins_of(input logic [15:0] f);
        pins_of = {f[13:10], f[7:6], f[3:0]}; // R22
    endfunction : pins_of

    hcr_clk_if cif (); // Link to the clock generator.

    // Bus side state.
    logic ack_q; // Registered acknowledge.
    logic [31:0] dat_q; // Registered read data.
    logic go_q; // One-cycle pulse that runs the loaded report.
    logic get_q; // Report direction: one for control-in.
    logic [3:0] len_q; // Transfer size in bytes.
    logic done_q; // Last report finished.
    logic reject_q; // Last report refused.
    logic [9:0] level_q; // Software output level of each GPIO.
    logic [9:0] meta_q; // First synchroniser stage of the pins.
    logic [9:0] sync_q; // Synchronised pin levels.
    hcr_byte_t buf_q [0:`HCR_BUF_BYTES-1]; // Report byte buffer.
    hcr_byte_t rsp [0:`HCR_BUF_BYTES-1]; // Answer image for a get.

    // Configuration state.
    logic [15:0] lock_q; // Field lock bits, zero means locked.
    logic txw_q; // Transmit wide mode.
    logic rxw_q; // Receive wide mode.
    logic lowlat_q; // Low latency receive.
    logic [15:0] dir_q; // Pin direction field.
    logic [15:0] drv_q; // Pin drive type field.
    logic [15:0] pu_q; // Pull-up field.
    logic [15:0] pd_q; // Pull-down field.
    hcr_byte_t divhi_q; // Clock high divisor.
    hcr_byte_t divlo_q; // Clock low divisor.
    hcr_byte_t mode0_q; // Half-duplex control byte.
    hcr_byte_t mode1_q; // Clock and toggle control byte.
    logic boot_q; // Set until stored pin defaults are loaded.

    // Bus decode.
    wire wb_req = wb_cyc_i && wb_stb_i;
    wire ack_d = wb_req && !ack_q;
    wire wr_now = wb_req && wb_we_i && ack_q;
    wire hit_ctrl = wb_adr_i == `HCR_REG_CTRL;
    wire hit_stat = wb_adr_i == `HCR_REG_STATUS;
    wire hit_level = wb_adr_i == `HCR_REG_GPIO_LEVEL;
    wire hit_in = wb_adr_i == `HCR_REG_GPIO_IN;
    wire hit_lock = wb_adr_i == `HCR_REG_LOCK;
    wire [3:0] buf_idx = wb_adr_i[5:2];
    wire hit_buf = (wb_adr_i[6] == 1'(`HCR_REG_BUF_BASE >> 6))
        && (buf_idx < 4'(`HCR_BUF_BYTES)) && (wb_adr_i[1:0] == 2'h0);
    wire [31:0] rd_buf = hit_buf ? {24'h000000, buf_q[buf_idx]} : 32'h00000000;
    wire [31:0] rd_data =
        hit_ctrl ? {20'h00000, len_q, 6'h00, get_q, 1'b0} :
        hit_stat ? {30'h00000000, reject_q, done_q} :
        hit_level ? {22'h000000, level_q} :
        hit_in ? {22'h000000, sync_q} :
        hit_lock ? {16'h0000, lock_q} : rd_buf;

    // Report dispatch on the leading code and the transfer size.
    wire [7:0] code = buf_q[0];
    wire ok_ver = (code == HCR_RPT_VERSION) && get_q && (len_q == `HCR_LEN_VERSION); // R01
    wire ok_lock = (code == HCR_RPT_LOCK) && (len_q == `HCR_LEN_LOCK); // R02
    wire ok_xfer = (code == HCR_RPT_XFER) && (len_q == `HCR_LEN_XFER); // R07
    wire ok_pins = (code == HCR_RPT_PINS) && (len_q == `HCR_LEN_PINS); // R10
    wire accept = ok_ver || ok_lock || ok_xfer || ok_pins; // R23
    wire do_set = go_q && accept && !get_q;
    wire do_get = go_q && accept && get_q;
    wire [15:0] wr_word = {buf_q[1], buf_q[2]};
    // Only ones can turn into zeros; reserved bits stay as they read.
    wire [15:0] lock_d = lock_q & (wr_word | ~`HCR_LOCK_VALID); // R03 R04 R05 R06

    // Answer image: untouched bytes read back as loaded.
    always_comb begin
        for (int i = 0; i < `HCR_BUF_BYTES; i++) begin
            rsp[i] = buf_q[i];
        end
        if (code == HCR_RPT_VERSION) begin
            rsp[1] = PRODUCT_ID_LOW; // R01
            rsp[2] = REVISION;
            for (int i = 3; i < 7; i++) begin
                rsp[i] = 8'h00;
            end
        end else if (code == HCR_RPT_LOCK) begin
            rsp[1] = lock_q[15:8]; // R02
            rsp[2] = lock_q[7:0];
        end else if (code == HCR_RPT_XFER) begin
            rsp[1] = {7'h00, txw_q}; // R07
            rsp[2] = {6'h00, lowlat_q, rxw_q}; // R08 R09
        end else if (code == HCR_RPT_PINS) begin
            {rsp[1], rsp[2]} = dir_q; // R10
            {rsp[3], rsp[4]} = drv_q;
            {rsp[5], rsp[6]} = pu_q;
            {rsp[7], rsp[8]} = pd_q;
            rsp[9] = divhi_q;
            rsp[10] = divlo_q;
            rsp[11] = mode0_q;
            rsp[12] = mode1_q;
        end
    end

    // Pin function decode.
    wire [2:0] modem = mode0_q[`HCR_M0_MODEM_MSB:0];
    wire [1:0] rs485_sel = mode0_q[`HCR_M0_RS485_MSB:`HCR_M0_RS485_LSB];
    wire modem_rts = (modem == 3'h1) || (modem == 3'h3) || (modem == 3'h4);
    wire [9:0] sf_mask = { // R19
        {2{modem == 3'h2}}, 2'b00,
        mode1_q[`HCR_M1_RXT_EN], mode1_q[`HCR_M1_TXT_EN],
        rs485_sel != 2'h0, modem == 3'h1, modem_rts,
        mode1_q[`HCR_M1_CLK_EN]}; // R21
    wire [9:0] dir_p = pins_of(dir_q);
    wire [9:0] drv_p = pins_of(drv_q);
    wire [9:0] pu_p = pins_of(pu_q);
    wire [9:0] pd_p = pins_of(pd_q);
    // Open drain drives only the low level; push-pull drives both.
    wire [9:0] gpio_oe = dir_p & (drv_p | ~level_q); // R11 R12
    wire [9:0] sf_o = {sf_level[9:1], cif.clk_level};
    wire [9:0] sf_oe = {sf_drive[9:1], 1'b1};
    wire [9:0] oe_d = (sf_mask & sf_oe) | (~sf_mask & gpio_oe); // R16
    wire [9:0] o_d = (sf_mask & sf_o) | (~sf_mask & level_q);
    wire [9:0] pu_d = ~sf_mask & ~dir_p & pu_p; // R13 R16
    wire [9:0] pd_d = ~sf_mask & ~dir_p & pd_p & ~pu_p; // R14

    assign cif.div_hi = divhi_q; // R18
    assign cif.div_lo = divlo_q;
    assign cif.enable = mode1_q[`HCR_M1_CLK_EN];

    hcr_clkgen u_clkgen (
        .clk_sys(clk_sys),
        .reset(reset),
        .cif(cif.gen)
    );

    // Bus answer: ack one cycle after the request, data with it.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            dat_q <= (ack_d && !wb_we_i) ? rd_data : 32'h00000000;
        end
    end

    // Control, status and GPIO level registers; a finish wins over a new start.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            go_q <= 1'b0;
            get_q <= 1'b0;
            len_q <= 4'h0;
            done_q <= 1'b0;
            reject_q <= 1'b0;
            level_q <= 10'h000;
        end else begin
            go_q <= wr_now && hit_ctrl && wb_sel_i[0] && wb_dat_i[`HCR_CTRL_GO];
            if (wr_now && hit_ctrl && wb_sel_i[0]) begin
                get_q <= wb_dat_i[`HCR_CTRL_GET];
            end
            if (wr_now && hit_ctrl && wb_sel_i[1]) begin
                len_q <= wb_dat_i[`HCR_CTRL_LEN_LSB+3:`HCR_CTRL_LEN_LSB];
            end
            if (go_q) begin
                done_q <= 1'b1;
                reject_q <= !accept; // R23
            end else if (wr_now && hit_ctrl && wb_sel_i[0] && wb_dat_i[`HCR_CTRL_GO]) begin
                done_q <= 1'b0;
                reject_q <= 1'b0;
            end
            if (wr_now && hit_level) begin
                level_q <= {wb_sel_i[1] ? wb_dat_i[9:8] : level_q[9:8],
                    wb_sel_i[0] ? wb_dat_i[7:0] : level_q[7:0]};
            end
        end
    end

    // Report buffer: a get overwrites it with the answer image.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `HCR_BUF_BYTES; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (do_get) begin
            for (int i = 0; i < `HCR_BUF_BYTES; i++) begin
                buf_q[i] <= rsp[i];
            end
        end else if (wr_now && hit_buf && wb_sel_i[0]) begin
            buf_q[buf_idx] <= wb_dat_i[7:0];
        end
    end

    // Lock bits and transfer mode.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lock_q <= `HCR_LOCK_RESET;
            txw_q <= `HCR_TXW_RESET; // R07
            rxw_q <= `HCR_RXW_RESET; // R08
            lowlat_q <= `HCR_LOWLAT_RESET; // R09
        end else if (do_set && ok_lock) begin
            lock_q <= lock_d; // R04
        end else if (do_set && ok_xfer) begin
            txw_q <= buf_q[1][0]; // R07
            rxw_q <= buf_q[2][0]; // R08
            lowlat_q <= buf_q[2][1]; // R09
        end
    end

    // Pin setup: stored defaults load once after reset, then report writes apply.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            boot_q <= 1'b1;
            dir_q <= 16'h0000;
            drv_q <= 16'h0000;
            pu_q <= 16'h0000;
            pd_q <= 16'h0000;
            divhi_q <= `HCR_DIV_RESET;
            divlo_q <= `HCR_DIV_RESET;
            mode0_q <= `HCR_MODE0_RESET;
            mode1_q <= `HCR_MODE1_RESET;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            dir_q <= stored_dir; // R17
            drv_q <= stored_drv;
            pu_q <= stored_pu;
            pd_q <= stored_pd;
        end else if (do_set && ok_pins) begin
            dir_q <= wr_word; // R10 R15
            drv_q <= {buf_q[3], buf_q[4]};
            pu_q <= {buf_q[5], buf_q[6]};
            pd_q <= {buf_q[7], buf_q[8]};
            divhi_q <= buf_q[9]; // R18
            divlo_q <= buf_q[10];
            mode0_q <= buf_q[11]; // R19
            mode1_q <= buf_q[12];
        end
    end

    // Pin synchroniser and registered pin level, enable and pull outputs.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_q <= 10'h000;
            sync_q <= 10'h000;
            pin_o <= 10'h000;
            pin_oe_n <= 10'h3FF;
            pin_pu_en <= 10'h000;
            pin_pd_en <= 10'h000;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            pin_o <= o_d;
            pin_oe_n <= ~oe_d; // R11 R12 R16
            pin_pu_en <= pu_d; // R13
            pin_pd_en <= pd_d; // R14
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign tx_wide = txw_q;
    assign rx_wide = rxw_q;
    assign low_latency = lowlat_q;
    assign lock_state = lock_q;

    // A version get leaves product byte and revision in the buffer.
    a_version_reply: assert property (go_q && get_q && ok_ver // R01
        |=> buf_q[1] == PRODUCT_ID_LOW && buf_q[2] == REVISION && done_q && !reject_q)
        else $error("Version answer wrong.");
    // A lock write clears exactly the zero bits of real fields.
    a_lock_write_and: assert property (do_set && ok_lock // R03
        |=> lock_q == ($past(lock_q) & ($past(wr_word) | ~`HCR_LOCK_VALID)))
        else $error("Lock update wrong.");
    // No lock bit ever returns to one.
    a_lock_no_unlock: assert property (1'b1 |=> (lock_q & ~$past(lock_q)) == 16'h0000) // R04
        else $error("Locked field was unlocked.");
    // Transfer mode write takes both bytes.
    a_xfer_write: assert property (do_set && ok_xfer // R08
        |=> {txw_q, rxw_q, lowlat_q} == {$past(buf_q[1][0]), $past(buf_q[2][1:0]) == 2'h3
            ? 2'b11 : {$past(buf_q[2][0]), $past(buf_q[2][1])}})
        else $error("Transfer mode not taken.");
    // A refused report sets the flag and leaves lock, direction, mode 1 and TX wide unchanged.
    a_reject_keep: assert property (go_q && !accept |=> reject_q && done_q // R23
        && $stable(lock_q) && $stable(dir_q) && $stable(mode1_q) && $stable(txw_q))
        else $error("Refused report changed state.");
    // Pin setup write lands in direction, drive, low divisor and mode 1 at the next edge.
    a_pins_apply: assert property (do_set && ok_pins // R15
        |=> dir_q == $past(wr_word) && drv_q == $past({buf_q[3], buf_q[4]})
            && divlo_q == $past(buf_q[10]) && mode1_q == $past(buf_q[12]))
        else $error("Pin setup not applied.");
    // Pull-up and pull-down never both on, and never on a special pin.
    a_pull_prio: assert property (1'b1 |=> (pin_pu_en & pin_pd_en) == 10'h000 // R14
        && ((pin_pu_en | pin_pd_en) & $past(sf_mask)) == 10'h000)
        else $error("Pull enables conflict.");
    // An input GPIO is never driven.
    a_input_undriven: assert property (1'b1 // R11
        |=> (~pin_oe_n & ~$past(sf_mask) & ~$past(dir_p)) == 10'h000)
        else $error("Input pin driven.");
endmodule : hcr_top

// file: verification/hcr_pin_model.sv
// Board side of the pins: resolves each wire from drivers and weak pulls.
`timescale 1ns/1ps
module hcr_pin_model (
    input wire logic clk_sys,
    input wire logic [9:0] pin_o,
    input wire logic [9:0] pin_oe_n,
    input wire logic [9:0] pin_pu_en,
    input wire logic [9:0] pin_pd_en,
    output logic [9:0] pin_i
);
    logic [9:0] float_q; // Floating lines wander every cycle.
    initial float_q = 10'h155;
    // A line nobody holds changes each cycle, so no stale level can pass for a real one.
    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    // A driven line shows the driver; otherwise pull-up wins over pull-down.
    assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & pin_pu_en)
        | (pin_oe_n & ~pin_pu_en & ~pin_pd_en & float_q);
endmodule : hcr_pin_model

// file: verification/hcr_top_test.sv
// Self-checking bench for the report handler.
`timescale 1ns/1ps
module hcr_top_test;
    import hcr_pkg::*;
    logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_wide, rx_wide, low_latency;
    logic [6:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic [9:0] pin_i, pin_o, pin_oe_n, pin_pu_en, pin_pd_en, sf_level, sf_drive;
    logic [9:0] dp, up, dn, sp, lv, eo, kn;
    logic pv; // Previous sample of the clock pin.
    logic [15:0] stored_dir, stored_drv, stored_pu, stored_pd, lock_state, f [4];
    logic [7:0] bq [13], sv [13]; // Report bytes to load and a copy of the last set.
    int mismatches, cmp_count, cyc_n, lk, cnt;
    hcr_top uut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en), .sf_level(sf_level),
        .sf_drive(sf_drive), .stored_dir(stored_dir), .stored_drv(stored_drv),
        .stored_pu(stored_pu), .stored_pd(stored_pd), .tx_wide(tx_wide), .rx_wide(rx_wide),
        .low_latency(low_latency), .lock_state(lock_state));
    hcr_pin_model pm (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en), .pin_i(pin_i));
    // Field bits to pin order.
    function automatic logic [9:0] fm(input logic [15:0] v);
        return {v[13:10], v[7:6], v[3:0]};
    endfunction : fm
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    // Counts and reports one comparison.
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    // One classic Wishbone cycle; read data is taken at the ack edge.
    task automatic wb(input logic we, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    // Loads the bytes, starts the report and checks its status.
    task automatic run(input logic [3:0] len, input logic get, input logic [7:0] st);
        for (int i = 0; i < len; i++) wb(1'b1, 7'(8'h40 + 4 * i), {24'h0, bq[i]});
        wb(1'b1, 7'h00, {20'h0, len, 6'h0, get, 1'b1});
        wb(1'b0, 7'h04, 32'h0);
        check(r[1:0], st[1:0]);
    endtask : run
    // Free-running clock.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Cuts a hang short.
    always @(posedge clk_sys) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            mismatches++;
            wrap_up();
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(32'hebf1));
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {3'h0, 7'h0, 32'h0, 4'hF};
        sf_level = 10'($urandom);
        sf_drive = 10'($urandom);
        stored_dir = 16'($urandom);
        stored_drv = 16'hFFFF;
        stored_pu = 16'($urandom);
        stored_pd = 16'h0;
        reset = 1'b1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({tx_wide, rx_wide, low_latency, lock_state}, {3'h1, 16'hFF8F});
        dp = fm(stored_dir);
        check(pin_oe_n & 10'h3F9, ~dp & 10'h3F9);
        check(pin_pu_en & ~dp & 10'h3F9, fm(stored_pu) & ~dp & 10'h3F9);
        for (int k = 0; k < 4; k++) begin
            cnt = $urandom;
            bq[0] = 8'h48;
            bq[1] = {7'h0, cnt[0]};
            bq[2] = {6'h0, cnt[2:1]};
            run(4'h3, 1'b0, 8'h1);
            check({tx_wide, rx_wide, low_latency}, {cnt[0], cnt[1], cnt[2]});
        end
        bq[0] = 8'h46;
        run(4'h7, 1'b1, 8'h1);
        wb(1'b0, 7'h44, 32'h0);
        check(r[7:0], 8'hA5);
        wb(1'b0, 7'h48, 32'h0);
        check(r[7:0], 8'h3C);
        run(4'h7, 1'b0, 8'h3);
        bq[0] = 8'h50;
        run(4'h3, 1'b0, 8'h3);
        bq[0] = 8'h48;
        bq[2] = 8'h0;
        run(4'h4, 1'b0, 8'h3);
        check(low_latency, cnt[2]);
        lk = 16'hFF8F;
        for (int k = 0; k < 3; k++) begin
            f[0] = (k == 0) ? 16'($urandom) : ((k == 1) ? 16'hFFFF : 16'h0);
            bq[0] = 8'h47;
            {bq[1], bq[2]} = f[0];
            run(4'h3, 1'b0, 8'h1);
            lk = lk & (f[0] | 16'h0070);
            check(lock_state, lk[15:0]);
            run(4'h3, 1'b1, 8'h1);
            wb(1'b0, 7'h44, 32'h0);
            check(r[7:0], lk[15:8]);
            wb(1'b0, 7'h48, 32'h0);
            check(r[7:0], lk[7:0]);
        end
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 4; j++) f[j] = 16'($urandom);
            bq[0] = 8'h49;
            for (int j = 0; j < 4; j++) {bq[2 * j + 1], bq[2 * j + 2]} = f[j];
            bq[9] = (k == 2) ? 8'h1 : 8'($urandom);
            bq[10] = (k == 2) ? 8'h1 : 8'($urandom);
            bq[11] = 8'h0;
            bq[12] = (k == 2) ? 8'h41 : 8'h0;
            lv = 10'($urandom);
            wb(1'b1, 7'h08, {22'h0, lv});
            run(4'hD, 1'b0, 8'h1);
            repeat (4) @(posedge clk_sys);
            dp = fm(f[0]);
            up = fm(f[2]);
            dn = fm(f[3]);
            sp = {5'h0, bq[12][6], 3'h0, bq[12][0]};
            eo = ~(dp & (fm(f[1]) | ~lv));
            check(pin_oe_n & ~sp, eo & ~sp);
            check(pin_pu_en & ~dp & ~sp, up & ~dp & ~sp);
            check(pin_pd_en & ~dp & ~sp, dn & ~up & ~dp & ~sp);
            check((pin_pu_en | pin_pd_en) & sp, 10'h0);
            if (k == 2) check(pin_oe_n[4:0], {~sf_drive[4], eo[3:1], 1'b0});
            kn = ~sp & (~eo | ((up | dn) & ~dp));
            wb(1'b0, 7'h0C, 32'h0);
            check(r[9:0] & kn, ((~eo & lv) | (eo & up & ~dp)) & kn);
            // Divisors of one give 12 MHz: 48 level changes in 100 system cycles.
            pv = pin_o[0];
            cnt = 0;
            for (int j = 0; j < 100; j++) begin
                @(posedge clk_sys);
                if (pin_o[0] !== pv) cnt++;
                pv = pin_o[0];
            end
            check(cnt, (k == 2) ? 48 : 0);
            sv = bq;
            for (int j = 1; j < 13; j++) bq[j] = 8'h0;
            run(4'hD, 1'b1, 8'h1);
            for (int j = 1; j < 13; j++) begin
                wb(1'b0, 7'(8'h40 + 4 * j), 32'h0);
                cnt = (j > 8) ? 8'hFF : ((j % 2) ? 8'h3C : 8'hCF);
                check(r[7:0] & cnt[7:0], sv[j] & cnt[7:0]);
            end
        end
        wrap_up();
    end
endmodule : hcr_top_test
